// *** hw/serial_port_control_status.sv ***
`timescale 1ns/1ps
module serial_port_control_status (
  input  wire logic        clk_sys,     // System clock
  input  wire logic        reset,       // Async reset, active high
  input  wire logic        ce,          // Clock enable
  input  wire logic [5:0]  address,     // Avalon byte address
  input  wire logic        read,        // Avalon read
  input  wire logic        write,       // Avalon write
  input  wire logic [31:0] writedata,   // Avalon write data
  output logic      [31:0] readdata,    // Avalon read data
  output logic             waitrequest, // Avalon wait
  input  wire logic        rxd,         // Serial input pin
  output logic             txd,         // Serial output pin
  output logic             txd_oe,      // Output enable of txd
  output logic             irq          // Interrupt request
);

  spc_pkg::ctrl_t   ctrl_q;             // Control register
  spc_pkg::cfg_t    cfg_q;              // Format options
  spc_pkg::status_t arm_q;              // Flags seen by status read
  logic [12:0]      baud_q;             // Clocks per bit
  logic [7:0]       tdr_q;              // Transmit data
  logic [7:0]       rdr_q;              // Receive data
  logic             ack_q;              // Bus answer cycle
  logic [31:0]      rdata_q;            // Captured read data
  logic             tx_empty_q;         // Transmit data empty
  logic             done_q;             // Transmission complete
  logic             rx_full_q;          // Receive data full
  logic             idle_q;             // Idle line flag
  logic             ovr_q;              // Overrun flag
  logic             pre_pend_q;         // Preamble queued
  logic             brk_pend_q;         // One break queued
  logic [12:0]      tx_cnt_q;           // Transmit bit timer
  logic [3:0]       bits_left_q;        // Bits left in tx frame
  logic [12:0]      sh_q;               // Transmit shifter
  logic             txd_q;              // Line level
  logic             rx_m_q;             // Sync stage one
  logic             rx_s_q;             // Sync stage two
  logic [12:0]      rx_cnt_q;           // Receive bit timer
  logic [3:0]       rx_bits_q;          // Bits left in rx frame
  logic [10:0]      rx_sh_q;            // Receive shifter
  logic [3:0]       ones_q;             // Consecutive ones
  logic             idle_arm_q;         // Frame seen since idle
  logic             irq_q;              // Registered interrupt

  logic             acc;                // Request accepted
  logic             wr_acc;             // Accepted write
  logic             rd_acc;             // Accepted read
  logic [3:0]       idx;                // Register index
  logic [31:0]      rd_mux;             // Read data source
  spc_pkg::status_t stat;               // Live status
  logic [3:0]       frame_len;          // Data frame length
  logic [3:0]       brk_len;            // Break length
  logic             tx_tick;            // End of tx bit time
  logic             tx_busy;            // Frame on the line
  logic             frame_end;          // Ready for next frame
  logic             brk_load;           // Break starts
  logic             pre_load;           // Preamble starts
  logic             dat_load;           // Data byte starts
  logic             done_set;           // tx_done set term
  logic             done_clr;           // tx_done clear term
  logic             data_wr;            // Data register write
  logic             data_rd;            // Data register read
  logic             rx_tick;            // Receive sample point
  logic             rx_end;             // Stop bit sampled
  logic [10:0]      rx_sh_n;            // Shifter with new bit
  logic [7:0]       rx_byte;            // Received data
  logic             idle_hit;           // Idle length reached

  // Bus decode; the answer comes one cycle after the request
  assign idx         = address[5:2];
  assign acc         = (read | write) & ack_q;
  assign wr_acc      = write & ack_q;
  assign rd_acc      = read & ack_q;
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata    = rdata_q;
  assign data_wr     = wr_acc && idx == spc_pkg::IDX_DATA_LOW;
  assign data_rd     = rd_acc && idx == spc_pkg::IDX_DATA_LOW;

  // Live status word
  assign stat = '{tx_empty_flag: tx_empty_q, tx_done_flag: done_q,
                  rx_full_flag: rx_full_q, idle_flag: idle_q,
                  overrun_flag: ovr_q, unused: 3'h0};

  // Frame lengths for the selected format
  assign frame_len = cfg_q.nine_bit_mode ? spc_pkg::LEN_FRAME9
                                         : spc_pkg::LEN_FRAME8;
  always_comb begin
    if (!cfg_q.long_break_select) begin
      brk_len = frame_len;
    end else if (cfg_q.nine_bit_mode) begin
      brk_len = spc_pkg::LEN_LBRK9;
    end else begin
      brk_len = spc_pkg::LEN_LBRK8;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    unique case (idx)
      spc_pkg::IDX_CTRL_TWO: rd_mux = {24'h0000_00, ctrl_q};
      spc_pkg::IDX_STAT_ONE: rd_mux = {24'h0000_00, stat};
      spc_pkg::IDX_DATA_LOW: rd_mux = {24'h0000_00, rdr_q};
      spc_pkg::IDX_CFG:      rd_mux = {30'h0000_0000, cfg_q};
      spc_pkg::IDX_BAUD:     rd_mux = {19'h0_0000, baud_q};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // Answer strobe and read data capture
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= (read | write) & ~ack_q;
      if (read && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Control register; software write beats hardware wakeup
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q <= spc_pkg::CTRL_RESET;
    end else if (ce) begin
      if (wr_acc && idx == spc_pkg::IDX_CTRL_TWO) begin
        ctrl_q <= writedata[7:0];
      end else if (idle_hit && ctrl_q.rx_wakeup_standby) begin
        ctrl_q.rx_wakeup_standby <= 1'b0;
      end
    end
  end

  // Format, rate and transmit data; status writes fall through
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_q  <= spc_pkg::CFG_RESET;
      baud_q <= spc_pkg::BAUD_RESET;
      tdr_q  <= spc_pkg::DATA_RESET;
    end else if (ce && wr_acc) begin
      if (idx == spc_pkg::IDX_CFG) begin
        cfg_q <= writedata[1:0];
      end
      if (idx == spc_pkg::IDX_BAUD) begin
        baud_q <= writedata[12:0];
      end
      if (idx == spc_pkg::IDX_DATA_LOW) begin
        tdr_q <= writedata[7:0];
      end
    end
  end

  // status read arms, data access disarms
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      arm_q <= '0;
    end else if (ce) begin
      if (rd_acc && idx == spc_pkg::IDX_STAT_ONE) begin
        arm_q <= rdata_q[7:0];
      end else if (data_rd || data_wr) begin
        arm_q <= '0;
      end
    end
  end

  // Preamble and single-break requests
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl_q.tx_enable) begin
        pre_pend_q <= 1'b0;
        brk_pend_q <= 1'b0;
      end else begin
        if (pre_load) begin
          pre_pend_q <= 1'b0;
        end
        if (brk_load) begin
          brk_pend_q <= 1'b0;
        end
      end
      if (wr_acc && idx == spc_pkg::IDX_CTRL_TWO) begin
        if (writedata[3] && !ctrl_q.tx_enable) begin
          pre_pend_q <= 1'b1;
        end
        if (writedata[0] && !ctrl_q.send_break) begin
          brk_pend_q <= 1'b1;
        end
      end
    end
  end

  // Transmit bit timer
  assign tx_tick = ctrl_q.tx_enable && baud_q != 13'h0000 &&
                   tx_cnt_q == 13'h0000;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_cnt_q <= 13'h0000;
    end else if (ce) begin
      if (!ctrl_q.tx_enable || tx_cnt_q == 13'h0000) begin
        tx_cnt_q <= baud_q - 13'h0001;
      end else begin
        tx_cnt_q <= tx_cnt_q - 13'h0001;
      end
    end
  end

  // Next frame choice: break, then preamble, then data
  assign tx_busy   = bits_left_q != 4'h0;
  assign frame_end = tx_tick && bits_left_q <= 4'h1;
  assign brk_load  = frame_end && (ctrl_q.send_break || brk_pend_q);
  assign pre_load  = frame_end && !brk_load && pre_pend_q;
  assign dat_load  = frame_end && !brk_load && !pre_pend_q &&
                     !tx_empty_q;

  assign txd_oe = ctrl_q.tx_enable;
  assign txd    = txd_q;

  // Transmit shifter and line level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bits_left_q <= 4'h0;
      sh_q        <= '1;
      txd_q       <= 1'b1;
    end else if (ce) begin
      if (!ctrl_q.tx_enable) begin
        bits_left_q <= 4'h0;
        sh_q        <= '1;
        txd_q       <= 1'b1;
      end else if (brk_load) begin
        bits_left_q <= brk_len;
        sh_q        <= 13'h0000;
        txd_q       <= 1'b0;
      end else if (pre_load) begin
        bits_left_q <= frame_len;
        sh_q        <= '1;
        txd_q       <= 1'b1;
      end else if (dat_load) begin
        // Start bit out, data then stop bits follow
        bits_left_q <= frame_len;
        sh_q        <= {5'h1F, tdr_q};
        txd_q       <= 1'b0;
      end else if (frame_end) begin
        bits_left_q <= 4'h0;
        txd_q       <= 1'b1;
      end else if (tx_tick) begin
        bits_left_q <= bits_left_q - 4'h1;
        sh_q        <= {1'b1, sh_q[12:1]};
        txd_q       <= sh_q[0];
      end
    end
  end

  // Transmit data empty flag; hardware set wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_empty_q <= 1'b1;
    end else if (ce) begin
      if (dat_load) begin
        tx_empty_q <= 1'b1;
      end else if (data_wr && arm_q.tx_empty_flag) begin
        tx_empty_q <= 1'b0;
      end
    end
  end

  // Transmission complete terms
  // low while anything is sent
  // low when anything is queued
  // Armed data write queues a byte: clear on that same edge
  assign done_clr = tx_busy || pre_pend_q || brk_pend_q ||
                    ctrl_q.send_break || !tx_empty_q ||
                    (data_wr && (arm_q.tx_done_flag || arm_q.tx_empty_flag));
  assign done_set = tx_empty_q && !tx_busy;

  // Transmission complete flag
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      done_q <= 1'b1;
    end else if (ce) begin
      if (done_clr) begin
        done_q <= 1'b0;
      end else if (done_set) begin
        done_q <= 1'b1;
      end
    end
  end

  // Two-stage synchroniser for the line input
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else if (ce) begin
      rx_m_q <= rxd;
      rx_s_q <= rx_m_q;
    end
  end

  // Receive timing and frame assembly
  assign rx_tick = ctrl_q.rx_enable && baud_q != 13'h0000 &&
                   rx_cnt_q == 13'h0000;
  assign rx_end  = rx_tick && rx_bits_q == 4'h1;
  assign rx_sh_n = {rx_s_q, rx_sh_q[10:1]};
  assign rx_byte = cfg_q.nine_bit_mode ? rx_sh_n[8:1] : rx_sh_n[9:2];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_cnt_q  <= 13'h0000;
      rx_bits_q <= 4'h0;
      rx_sh_q   <= '1;
    end else if (ce) begin
      if (!ctrl_q.rx_enable) begin
        rx_cnt_q  <= 13'h0000;
        rx_bits_q <= 4'h0;
      end else if (rx_bits_q == 4'h0 && !rx_s_q) begin
        // Start edge: sample mid-bit from here on
        rx_cnt_q  <= {1'b0, baud_q[12:1]};
        rx_bits_q <= frame_len;
      end else if (rx_tick) begin
        rx_cnt_q <= baud_q - 13'h0001;
        if (rx_bits_q != 4'h0) begin
          rx_bits_q <= rx_bits_q - 4'h1;
          rx_sh_q   <= rx_sh_n;
        end
      end else begin
        rx_cnt_q <= rx_cnt_q - 13'h0001;
      end
    end
  end

  // Idle line counter, in bit times of steady high
  assign idle_hit = rx_tick && rx_bits_q == 4'h0 && rx_s_q &&
                    ones_q == frame_len - 4'h1;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ones_q <= 4'h0;
    end else if (ce) begin
      if (!ctrl_q.rx_enable || rx_bits_q != 4'h0 || !rx_s_q) begin
        ones_q <= 4'h0;
      end else if (rx_tick && ones_q != frame_len) begin
        ones_q <= ones_q + 4'h1;
      end
    end
  end

  // Receive flags and data; a set beats an armed clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdr_q      <= spc_pkg::DATA_RESET;
      rx_full_q  <= 1'b0;
      ovr_q      <= 1'b0;
      idle_q     <= 1'b0;
      idle_arm_q <= 1'b0;
    end else if (ce) begin
      if (data_rd && arm_q.rx_full_flag) begin
        rx_full_q <= 1'b0;
      end
      if (data_rd && arm_q.overrun_flag) begin
        ovr_q <= 1'b0;
      end
      if (data_rd && arm_q.idle_flag) begin
        idle_q <= 1'b0;
      end
      if (rx_end && !ctrl_q.rx_wakeup_standby) begin
        if (rx_full_q && !(data_rd && arm_q.rx_full_flag)) begin
          ovr_q <= 1'b1;
        end else begin
          rdr_q      <= rx_byte;
          rx_full_q  <= 1'b1;
          idle_arm_q <= 1'b1;
        end
      end
      // idle after a full frame of ones
      if (idle_hit && idle_arm_q && !ctrl_q.rx_wakeup_standby) begin
        idle_q     <= 1'b1;
        idle_arm_q <= 1'b0;
      end
    end
  end

  // Interrupt request from enabled flags
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      // gate each source; standby gates receive
      irq_q <= (ctrl_q.tx_empty_irq_en && tx_empty_q) ||
               (ctrl_q.tx_done_irq_en && done_q) ||
               (!ctrl_q.rx_wakeup_standby &&
                ((ctrl_q.rx_full_irq_en && (rx_full_q || ovr_q)) ||
                 (ctrl_q.idle_irq_en && idle_q)));
    end
  end
  assign irq = irq_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_irq_tie;
    ce && ctrl_q.tx_empty_irq_en && tx_empty_q |=> irq;
  endproperty
  a_irq_tie: assert property (p_irq_tie)
    else $error("enabled tx_empty_flag gave no interrupt");

  property p_irq_tx_done_irq_en;
    ce && ctrl_q.tx_done_irq_en && done_q |=> irq;
  endproperty
  a_irq_tx_done_irq_en: assert property (p_irq_tx_done_irq_en)
    else $error("enabled tx_done_flag gave no interrupt");

  property p_irq_standby;
    ce && ctrl_q.rx_wakeup_standby && !ctrl_q.tx_empty_irq_en &&
      !ctrl_q.tx_done_irq_en |=> !irq;
  endproperty
  a_irq_standby: assert property (p_irq_standby)
    else $error("receiver interrupt during standby");

  property p_tx_off;
    ce && !ctrl_q.tx_enable |=> txd && !tx_busy;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("disabled transmitter still active");

  property p_busy_not_done;
    ce && tx_busy |=> !done_q;
  endproperty
  a_busy_not_done: assert property (p_busy_not_done)
    else $error("tx_done_flag set during a frame");

  property p_done_idle;
    done_q && ctrl_q.tx_enable |-> txd && tx_empty_q;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("tx_done_flag set with line not idle");

  property p_clear_wins;
    ce && data_wr && arm_q.tx_done_flag |=> !done_q;
  endproperty
  a_clear_wins: assert property (p_clear_wins)
    else $error("armed data write left tx_done_flag set");

  property p_load_empty;
    ce && dat_load |=> tx_empty_q && !txd ##1 !done_q;
  endproperty
  a_load_empty: assert property (p_load_empty)
    else $error("byte load did not set tx_empty_flag");

  property p_stat_write;
    ce && wr_acc && idx == spc_pkg::IDX_STAT_ONE |=>
      $stable(tdr_q) && $stable(baud_q) && $stable(cfg_q);
  endproperty
  a_stat_write: assert property (p_stat_write)
    else $error("status write changed state");

  property p_break_len;
    ce && brk_load |=> bits_left_q == $past(brk_len) && !txd;
  endproperty
  a_break_len: assert property (p_break_len)
    else $error("break frame has wrong length");

endmodule

// *** hw/spc_pkg.sv ***
package spc_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL_TWO = 4'h3;  // serial_control_two
  localparam logic [3:0] IDX_STAT_ONE = 4'h4;  // serial_status_one
  localparam logic [3:0] IDX_DATA_LOW = 4'h8;  // data_low_register
  localparam logic [3:0] IDX_CFG      = 4'h9;  // Format options
  localparam logic [3:0] IDX_BAUD     = 4'hA;  // Clocks per bit

  // Reset values
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [1:0]  CFG_RESET  = 2'h0;
  localparam logic [12:0] BAUD_RESET = 13'h0010;
  localparam logic [7:0]  DATA_RESET = 8'h00;

  // Frame lengths in bit times
  localparam logic [3:0] LEN_FRAME8 = 4'hA;    // 8-bit format
  localparam logic [3:0] LEN_FRAME9 = 4'hB;    // 9-bit format
  localparam logic [3:0] LEN_LBRK8  = 4'hD;    // Long break, 8-bit
  localparam logic [3:0] LEN_LBRK9  = 4'hE;    // Long break, 9-bit

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic idle_irq_en;
    logic tx_enable;
    logic rx_enable;
    logic rx_wakeup_standby;
    logic send_break;
  } ctrl_t;

  // Status register, bit 7 down to bit 0
  typedef struct packed {
    logic       tx_empty_flag;
    logic       tx_done_flag;
    logic       rx_full_flag;
    logic       idle_flag;
    logic       overrun_flag;
    logic [2:0] unused;
  } status_t;

  // Format options
  typedef struct packed {
    logic nine_bit_mode;
    logic long_break_select;
  } cfg_t;
endpackage

// *** tb/remote_uart.sv ***
`timescale 1ns/1ps
// Remote transceiver model on the serial line
module remote_uart #(
  parameter int BAUD = 4 // Clocks per bit
) (
  input  wire logic clk_sys, // System clock
  input  wire logic line,    // Resolved line from block
  output logic      rxd      // Line into block
);
  logic [7:0] got;     // Last byte caught
  int         got_cnt; // Frames caught
  int         run;     // Current low run
  int         low_len; // Last low run in clocks
  int         low_cnt; // Low runs seen
  // Send one frame, LSB first, line idles high after
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      rxd <= f[i];
      repeat (BAUD - 1) @(posedge clk_sys);
    end
  endtask
  // Catch frames by sampling bit centres
  initial begin
    rxd = 1'b1;
    got_cnt = 0;
    forever begin
      @(negedge line);
      repeat (BAUD / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD) @(posedge clk_sys);
        got[i] = line;
      end
      got_cnt++;
    end
  end
  // Measure each low run, used for breaks
  initial begin
    run = 0;
    low_cnt = 0;
    forever begin
      @(posedge clk_sys);
      if (line === 1'b0) begin
        run++;
      end else if (run != 0) begin
        low_len = run;
        low_cnt++;
        run = 0;
      end
    end
  end
endmodule

// *** tb/serial_port_control_status_bench.sv ***
`timescale 1ns/1ps
// Self-checking bench for the control and status block
module serial_port_control_status_bench;
  logic        clk_sys, reset, read, write;  // Clock, reset, strobes
  logic        ce;                           // Clock enable to the block
  logic [5:0]  address;                      // Bus address
  logic [31:0] writedata, readdata;          // Bus data
  logic        waitrequest, rxd, txd, txd_oe; // Bus wait, line pins
  logic        irq, line;                    // Interrupt, resolved line
  logic [7:0]  v;                            // Scratch read value
  int          error_cnt, num_checks;        // Report counters
  // Line has a pull-up while the block does not drive it
  assign line = txd_oe ? txd : 1'b1;
  serial_port_control_status u_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe), .irq(irq));
  remote_uart #(.BAUD(4)) u_far (.clk_sys(clk_sys), .line(line), .rxd(rxd));
  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic we, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    write <= we;
    read <= ~we;
    writedata <= {24'h00_0000, wd};
    @(negedge clk_sys);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    v = readdata[7:0];
    @(posedge clk_sys);
    read <= 1'b0;
    write <= 1'b0;
    if (n == 50) begin
      $display("[ERR] %0t bus timeout", $time);
      error_cnt++;
      tally_and_finish();
    end
  endtask
  // Read until masked value matches
  task automatic poll(input logic [3:0] idx, input logic [7:0] m, input logic [7:0] w);
    for (int n = 0; n < 200; n++) begin
      bus(0, idx, 8'h00);
      if ((v & m) === w) return;
    end
    $display("[ERR] %0t poll timeout", $time);
    error_cnt++;
    tally_and_finish();
  endtask
  // Wait for a frame, a low run or the interrupt
  task automatic wait_far(input int which, input int prev);
    for (int n = 0; n < 800; n++) begin
      @(posedge clk_sys);
      if (which == 2 ? irq === 1'b1 : (which == 1 ? u_far.low_cnt : u_far.got_cnt) > prev)
        return;
    end
    $display("[ERR] %0t wait timeout", $time);
    error_cnt++;
    tally_and_finish();
  endtask
  task automatic t_regs;
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v, 8'hC0);
    bus(1, spc_pkg::IDX_STAT_ONE, 8'h38);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v, 8'hC0);
    bus(0, 4'hF, 8'h00); chk(v, 8'h00);
    chk(irq, 8'h00);
    chk(txd_oe, 8'h00);
  endtask
  task automatic t_tx;
    int p;
    bus(1, spc_pkg::IDX_BAUD, 8'h04);
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h08);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v & 8'h40, 8'h00);
    chk(txd_oe, 8'h01);
    poll(spc_pkg::IDX_STAT_ONE, 8'hC0, 8'hC0);
    p = u_far.got_cnt;
    bus(0, spc_pkg::IDX_DATA_LOW, 8'h00);
    bus(1, spc_pkg::IDX_DATA_LOW, 8'h5A);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v, 8'hC0);
    bus(1, spc_pkg::IDX_DATA_LOW, 8'hA5);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v & 8'h40, 8'h00);
    wait_far(0, p);
    chk(u_far.got, 8'hA5);
    poll(spc_pkg::IDX_STAT_ONE, 8'hC0, 8'hC0);
    chk(line, 8'h01);
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h88);
    bus(0, spc_pkg::IDX_CTRL_TWO, 8'h00); chk(irq, 8'h01);
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h48);
    bus(0, spc_pkg::IDX_CTRL_TWO, 8'h00); chk(irq, 8'h01);
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h08);
    bus(0, spc_pkg::IDX_CTRL_TWO, 8'h00); chk(irq, 8'h00);
  endtask
  // Break length; a freeze of frz clocks mid-break stretches it
  task automatic t_brk(input logic [7:0] cfg, input int len, input int frz);
    int p;
    bus(1, spc_pkg::IDX_CFG, cfg);
    p = u_far.low_cnt;
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h09);
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h08);
    for (int n = 0; n < 20 && line !== 1'b0; n++) @(posedge clk_sys);
    ce <= 1'b0;
    repeat (frz) @(posedge clk_sys);
    ce <= 1'b1;
    wait_far(1, p);
    chk(8'(u_far.low_len), 8'(len * 4 + frz));
    repeat (100) @(posedge clk_sys);
    chk(8'(u_far.low_cnt - p), 8'h01);
  endtask
  task automatic t_rx;
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h2C);
    u_far.send(8'h3C);
    wait_far(2, 0);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v & 8'h28, 8'h20);
    bus(0, spc_pkg::IDX_DATA_LOW, 8'h00); chk(v, 8'h3C);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v & 8'h20, 8'h00);
    chk(irq, 8'h00);
    u_far.send(8'h11);
    u_far.send(8'h22);
    // Stop bit is sampled a few clocks after the model returns
    repeat (8) @(posedge clk_sys);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v & 8'h28, 8'h28);
    bus(0, spc_pkg::IDX_DATA_LOW, 8'h00); chk(v, 8'h11);
    poll(spc_pkg::IDX_STAT_ONE, 8'h10, 8'h10);
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h1C);
    bus(0, spc_pkg::IDX_CTRL_TWO, 8'h00); chk(irq, 8'h01);
    bus(0, spc_pkg::IDX_DATA_LOW, 8'h00);
    bus(1, spc_pkg::IDX_CTRL_TWO, 8'h06);
    u_far.send(8'h77);
    poll(spc_pkg::IDX_CTRL_TWO, 8'h02, 8'h00);
    bus(0, spc_pkg::IDX_STAT_ONE, 8'h00); chk(v & 8'h20, 8'h00);
  endtask
  // Clock of 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    {address, read, write, writedata} = '0;
    ce = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_tx();
    t_brk(8'h00, 10, 3);
    t_brk(8'h01, 13, 0);
    t_rx();
    tally_and_finish();
  end
endmodule
